// *** logic/mms_map.svh ***
// Offsets, field positions, reset values and timing figures of the block.
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH

// Clock and time base.
`define MMS_CLK_NS 10
`define MMS_TICK_NS 1000

// Timing figures, in their own units.
`define MMS_T_INIT_MS 2000
`define MMS_T_RESET_MIN_US 2
`define MMS_T_LOW_POWER_PIN_US 100
`define MMS_T_INT_OFF_US 500
`define MMS_T_SELECT_US 100
`define MMS_T_LOS_MS 100
`define MMS_T_FLAG_MS 200

// Register byte offsets.
`define MMS_ADDR_W 8
`define MMS_OFS_STATUS 8'h00
`define MMS_OFS_FLAGS 8'h04
`define MMS_OFS_FLAG_MASK 8'h08
`define MMS_OFS_CONTROL 8'h0C
`define MMS_OFS_IRQ_STATUS 8'h10
`define MMS_OFS_IRQ_MASK 8'h14

// Status register fields.
`define MMS_ST_NOT_READY 0
`define MMS_ST_FUNCTIONAL 1
`define MMS_ST_LOW_POWER 2
`define MMS_ST_RESPONDING 3
`define MMS_ST_HELD 4

// Control register fields and reset value.
`define MMS_CTL_PDOWN 0
`define MMS_CTL_RESET 32'h0000_0000

// Interrupt status bits for the bus interrupt.
`define MMS_IRQ_W 4
`define MMS_IRQ_READY 0
`define MMS_IRQ_FLAG 1
`define MMS_IRQ_TXN_END 2
`define MMS_IRQ_MOD_RESET 3

`endif

// *** logic/mms_pkg.sv ***
// Types shared by the management status block.
`default_nettype none
package mms_pkg;

	typedef enum logic [1:0] {
		MMS_ST_HOLD,
		MMS_ST_INIT,
		MMS_ST_READY
	} mms_init_e;

endpackage
`default_nettype wire

// *** logic/mms_status.sv ***
// Management control, status and interrupt timing logic of the module.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mms_map.svh"

module mms_status
	import mms_pkg::*;
#(
	parameter int LANES = 4,
	parameter int INIT_US = (`MMS_T_INIT_MS * 1000 / 10) * 9
)
(
	// Clock and reset.
	input wire logic I_CLK,
	input wire logic I_RESET,
	// APB slave.
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [`MMS_ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_IRQ,
	// Module pins from the host.
	input wire logic I_MODULE_RESET_N,
	input wire logic I_MODULE_SELECT_N,
	input wire logic I_LOW_POWER_PIN,
	input wire logic I_SCL,
	input wire logic I_SDA,
	// Line conditions from the optics.
	input wire logic [LANES-1:0] I_RX_LOS,
	input wire logic [LANES-1:0] I_TX_FAULT,
	// Open-drain interrupt pin.
	output logic O_INTERRUPT_OUT_N_O,
	output logic O_INTERRUPT_OUT_N_OE_N,
	// Power and bus controls.
	output logic O_LOW_POWER,
	output logic O_BUS_RESPOND
);

	localparam int TICK_CYC = `MMS_TICK_NS / `MMS_CLK_NS;
	localparam int RST_CYC = (`MMS_T_RESET_MIN_US * 1000 + `MMS_CLK_NS - 1)
		/ `MMS_CLK_NS;
	localparam int INIT_LIMIT_US = `MMS_T_INIT_MS * 1000;
	localparam int SYNC_W = 5 + 2 * LANES;
	localparam int FLAG_W = 2 * LANES + 1;
	localparam int DIV_W = $clog2(TICK_CYC);
	localparam int RCNT_W = $clog2(RST_CYC + 1);
	localparam int INIT_W = $clog2(INIT_US + 1);

	if (LANES < 1 || LANES > 15)
		$error("LANES must lie between 1 and 15");
	if (INIT_US < 1 || INIT_US >= INIT_LIMIT_US)
		$error("INIT_US must be positive and below the initialisation bound");

	// Every pin passes two flip-flops before any logic reads it.
	// They reset to the idle pin levels so no false edge follows reset.
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {4'hF, {(1 + 2 * LANES){1'b0}}};
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	wire logic [SYNC_W-1:0] pins_in;
	wire logic scl_s;
	wire logic sda_s;
	wire logic mrst_n_s;
	wire logic sel_n_s;
	wire logic lp_s;
	wire logic [LANES-1:0] los_s;
	wire logic [LANES-1:0] fault_s;

	assign pins_in = {I_SCL, I_SDA, I_MODULE_RESET_N, I_MODULE_SELECT_N,
		I_LOW_POWER_PIN, I_RX_LOS, I_TX_FAULT};
	assign {scl_s, sda_s, mrst_n_s, sel_n_s, lp_s, los_s, fault_s} = sync2_reg;

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end
		else
		begin
			sync1_reg <= pins_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Microsecond time base.
	logic [DIV_W-1:0] div_reg;
	wire logic tick;

	assign tick = (div_reg == DIV_W'(TICK_CYC - 1));

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || tick)
			div_reg <= {DIV_W{1'b0}};
		else
			div_reg <= div_reg + DIV_W'(1);
	end

	// Reset pin qualification: short glitches are ignored.
	logic [RCNT_W-1:0] rlow_cnt_reg;
	logic held_reg;
	wire logic rlow_full;

	assign rlow_full = (rlow_cnt_reg == RCNT_W'(RST_CYC));

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || mrst_n_s)
			rlow_cnt_reg <= {RCNT_W{1'b0}};
		else if (!rlow_full)
			rlow_cnt_reg <= rlow_cnt_reg + RCNT_W'(1);
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			held_reg <= 1'b0;
		else if (mrst_n_s)
			held_reg <= 1'b0;
		else if (rlow_full)
			held_reg <= 1'b1;
	end

	// Initialisation sequence after power-on or a qualified reset.
	mms_init_e state_reg;
	mms_init_e state_next;
	logic [INIT_W-1:0] init_cnt_reg;
	wire logic init_end;
	wire logic ready;
	wire logic ready_pulse;
	wire logic mrst_pulse;

	assign init_end = tick && (init_cnt_reg == INIT_W'(INIT_US - 1));
	assign ready = (state_reg == MMS_ST_READY);
	assign ready_pulse = (state_reg == MMS_ST_INIT) && init_end;
	assign mrst_pulse = rlow_full && !held_reg && !mrst_n_s;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			MMS_ST_HOLD:
				if (!held_reg)
					state_next = MMS_ST_INIT;
			MMS_ST_INIT:
				if (held_reg)
					state_next = MMS_ST_HOLD;
				else if (init_end)
					state_next = MMS_ST_READY;
			MMS_ST_READY:
				if (held_reg)
					state_next = MMS_ST_HOLD;
			default:
				state_next = MMS_ST_INIT;
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			state_reg <= MMS_ST_INIT;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || state_reg != MMS_ST_INIT)
			init_cnt_reg <= {INIT_W{1'b0}};
		else if (tick)
			init_cnt_reg <= init_cnt_reg + INIT_W'(1);
	end

	// Two-wire bus watch: a stop, then the next falling clock edge.
	logic scl_d_reg;
	logic sda_d_reg;
	logic stop_pend_reg;
	wire logic stop_seen;
	wire logic scl_fall;
	wire logic txn_end;

	assign stop_seen = scl_s && scl_d_reg && sda_s && !sda_d_reg;
	assign scl_fall = scl_d_reg && !scl_s;
	assign txn_end = stop_pend_reg && scl_fall;

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			stop_pend_reg <= 1'b0;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			if (stop_seen)
				stop_pend_reg <= 1'b1;
			else if (scl_fall)
				stop_pend_reg <= 1'b0;
		end
	end

	// APB decode.
	wire logic setup_ph;
	wire logic access_ph;
	wire logic hit_status;
	wire logic hit_flags;
	wire logic hit_fmask;
	wire logic hit_ctrl;
	wire logic hit_istat;
	wire logic hit_imask;
	wire logic hit_any;
	wire logic wr_en;
	wire logic rd_flags;

	assign setup_ph = I_PSEL && !I_PENABLE;
	assign access_ph = I_PSEL && I_PENABLE;
	assign hit_status = (I_PADDR == `MMS_OFS_STATUS);
	assign hit_flags = (I_PADDR == `MMS_OFS_FLAGS);
	assign hit_fmask = (I_PADDR == `MMS_OFS_FLAG_MASK);
	assign hit_ctrl = (I_PADDR == `MMS_OFS_CONTROL);
	assign hit_istat = (I_PADDR == `MMS_OFS_IRQ_STATUS);
	assign hit_imask = (I_PADDR == `MMS_OFS_IRQ_MASK);
	assign hit_any = hit_status || hit_flags || hit_fmask || hit_ctrl
		|| hit_istat || hit_imask;
	assign wr_en = access_ph && I_PWRITE && hit_any;
	assign rd_flags = access_ph && !I_PWRITE && hit_flags;

	// Latched flags: loss per lane, fault per lane, then ready.
	logic [FLAG_W-1:0] flag_reg;
	logic [FLAG_W-1:0] fmask_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] prdata_reg;
	wire logic [FLAG_W-1:0] flag_set;
	wire logic [FLAG_W-1:0] flag_clr;
	wire logic flag_event;
	wire logic int_active;

	assign flag_set = {ready_pulse, fault_s, los_s};
	// Only bits that the read actually returned are cleared, so a flag that
	// rises between the setup and access cycles is not lost.
	assign flag_clr = rd_flags ? prdata_reg[FLAG_W-1:0] : {FLAG_W{1'b0}};
	assign flag_event = |(flag_set & ~flag_reg);
	assign int_active = |(flag_reg & ~fmask_reg);

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || held_reg)
			flag_reg <= {FLAG_W{1'b0}};
		else
			flag_reg <= (flag_reg & ~flag_clr) | flag_set;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			fmask_reg <= {FLAG_W{1'b0}};
			ctrl_reg <= `MMS_CTL_RESET;
		end
		else if (wr_en && hit_fmask)
			fmask_reg <= I_PWDATA[FLAG_W-1:0];
		else if (wr_en && hit_ctrl)
			ctrl_reg <= {31'h0000_0000, I_PWDATA[`MMS_CTL_PDOWN]};
	end

	// Bus interrupt: sticky events, write one to clear, set wins.
	logic [`MMS_IRQ_W-1:0] istat_reg;
	logic [`MMS_IRQ_W-1:0] imask_reg;
	wire logic [`MMS_IRQ_W-1:0] irq_ev;
	wire logic [`MMS_IRQ_W-1:0] irq_w1c;

	assign irq_ev = {mrst_pulse, txn_end, flag_event, ready_pulse};
	assign irq_w1c = (wr_en && hit_istat) ? I_PWDATA[`MMS_IRQ_W-1:0]
		: {`MMS_IRQ_W{1'b0}};

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			istat_reg <= {`MMS_IRQ_W{1'b0}};
			imask_reg <= {`MMS_IRQ_W{1'b0}};
		end
		else
		begin
			istat_reg <= (istat_reg & ~irq_w1c) | irq_ev;
			if (wr_en && hit_imask)
				imask_reg <= I_PWDATA[`MMS_IRQ_W-1:0];
		end
	end

	// Status word and read data, captured in the setup cycle.
	wire logic pdown;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_mux;

	assign pdown = ctrl_reg[`MMS_CTL_PDOWN];
	assign status_word = {27'h000_0000, held_reg, O_BUS_RESPOND,
		O_LOW_POWER, ready, !ready};
	assign rd_mux = hit_status ? status_word
		: hit_flags ? {{(32 - FLAG_W){1'b0}}, flag_reg}
		: hit_fmask ? {{(32 - FLAG_W){1'b0}}, fmask_reg}
		: hit_ctrl ? ctrl_reg
		: hit_istat ? {{(32 - `MMS_IRQ_W){1'b0}}, istat_reg}
		: hit_imask ? {{(32 - `MMS_IRQ_W){1'b0}}, imask_reg}
		: 32'h0000_0000;

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			prdata_reg <= 32'h0000_0000;
		else if (setup_ph)
			prdata_reg <= I_PWRITE ? 32'h0000_0000 : rd_mux;
	end

	// Pin-side outputs, one cycle from their synchronised causes; the interrupt pin two, through the latched flags.
	logic low_power_reg;
	logic respond_reg;
	logic int_reg;

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			low_power_reg <= 1'b0;
			respond_reg <= 1'b0;
			int_reg <= 1'b0;
		end
		else
		begin
			low_power_reg <= lp_s || pdown;
			respond_reg <= ready && !sel_n_s;
			int_reg <= int_active;
		end
	end

	assign O_PRDATA = prdata_reg;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = access_ph && !hit_any;
	assign O_IRQ = |(istat_reg & imask_reg);
	// The pin is only ever pulled low; the enable is low while driving.
	assign O_INTERRUPT_OUT_N_O = 1'b0;
	assign O_INTERRUPT_OUT_N_OE_N = !int_reg;
	assign O_LOW_POWER = low_power_reg;
	assign O_BUS_RESPOND = respond_reg;

endmodule
`default_nettype wire

// *** test/mms_status_properties.sv ***
// Port-level checks of the management status block.
`timescale 1ns/1ps
`default_nettype none
`include "mms_map.svh"

module mms_status_chk
#(
	parameter int LANES = 4
)
(
	// Clock, reset and register bus.
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [`MMS_ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic O_IRQ,
	// Pins and line conditions.
	input wire logic I_MODULE_RESET_N,
	input wire logic I_MODULE_SELECT_N,
	input wire logic I_LOW_POWER_PIN,
	input wire logic I_SCL,
	input wire logic I_SDA,
	input wire logic [LANES-1:0] I_RX_LOS,
	input wire logic [LANES-1:0] I_TX_FAULT,
	input wire logic O_INTERRUPT_OUT_N_O,
	input wire logic O_INTERRUPT_OUT_N_OE_N,
	input wire logic O_LOW_POWER,
	input wire logic O_BUS_RESPOND
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	wire logic acc = I_PSEL & I_PENABLE;
	wire logic mapped = I_PADDR <= 8'h14 && I_PADDR[1:0] == 2'h0;
	wire logic fl_rd = acc && !I_PWRITE && I_PADDR == `MMS_OFS_FLAGS;
	wire logic quiet = I_RX_LOS == '0 && I_TX_FAULT == '0;
	// Inverted mask of lane 0 receive loss, mirrored from bus writes.
	logic unmasked_reg;
	logic [8:0] low_cnt_reg;
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			unmasked_reg <= 1'b1;
		else if (acc && I_PWRITE && I_PADDR == `MMS_OFS_FLAG_MASK)
			unmasked_reg <= !I_PWDATA[0];
	end
	always_ff @(posedge I_CLK)
	begin
		if (I_MODULE_RESET_N)
			low_cnt_reg <= 9'h000;
		else if (low_cnt_reg != 9'h1FF)
			low_cnt_reg <= low_cnt_reg + 9'h001;
	end
	ready_always_a: assert property (acc |-> O_PREADY)
		else $error("pready low in access");
	unmapped_err_a: assert property (acc && !mapped |-> O_PSLVERR)
		else $error("unmapped access without error");
	reset_quiet_a: assert property ($fell(I_RESET) |->
		O_INTERRUPT_OUT_N_OE_N && !O_BUS_RESPOND && !O_IRQ)
		else $error("outputs active after reset");
	drain_low_a: assert property (!O_INTERRUPT_OUT_N_O)
		else $error("open drain data not low");
	los_pin_a: assert property ($rose(I_RX_LOS[0]) && unmasked_reg &&
		O_BUS_RESPOND |-> ##[1:6] !O_INTERRUPT_OUT_N_OE_N)
		else $error("receive loss did not pull the pin");
	low_power_a: assert property (I_LOW_POWER_PIN [*6] |-> O_LOW_POWER)
		else $error("low power not entered");
	deselect_a: assert property (I_MODULE_SELECT_N [*6] |-> !O_BUS_RESPOND)
		else $error("answers while deselected");
	read_release_a: assert property (quiet [*5] ##0 fl_rd |->
		##[1:3] O_INTERRUPT_OUT_N_OE_N)
		else $error("pin not released after read");
	reset_held_a: assert property (low_cnt_reg > 9'h0CE |-> !O_BUS_RESPOND)
		else $error("answers while module reset held");
	cover property (acc && !mapped);
	cover property (quiet [*5] ##0 fl_rd);
	cover property ($rose(I_RX_LOS[0]) && unmasked_reg && O_BUS_RESPOND);
	cover property (low_cnt_reg > 9'h0CE);
endmodule

bind mms_status mms_status_chk #(.LANES(LANES)) mms_status_chk_inst (.*);
`default_nettype wire

// *** test/mms_host_model.sv ***
// Host controller model: module pins and 2-wire frames.
`timescale 1ns/1ps
`default_nettype none

module mms_host_model
(
	// Clock for pin timing.
	input wire logic i_clk,
	// Pins towards the module.
	output logic o_reset_n,
	output logic o_select_n,
	output logic o_lp,
	output logic o_scl,
	output logic o_sda
);
	// Both bus lines rest at their pull-up level between frames.
	initial
	begin
		o_reset_n = 1'b1;
		o_select_n = 1'b0;
		o_lp = 1'b0;
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hold_reset(input int cyc);
		o_reset_n <= 1'b0;
		repeat (cyc) @(posedge i_clk);
		o_reset_n <= 1'b1;
	endtask
	// Start, ten clock pulses, stop, then the clock fall that ends the frame.
	// The first step is off the 10 ns grid so no line moves on a clock edge.
	task automatic frame();
		#43 o_sda = 1'b0;
		repeat (10)
		begin
			#40 o_scl = 1'b0;
			#40 o_scl = 1'b1;
		end
		#40 o_sda = 1'b1;
		#40 o_scl = 1'b0;
		#40 o_scl = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** test/mms_status_tb_top.sv ***
// Self-checking bench of the management status block.
`timescale 1ns/1ps
`default_nettype none
`include "mms_map.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
	mismatches++; $display("Error %s expected %h seen %h", nm, e, s); end end

module mms_status_tb_top;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0] los = 4'h0, flt = 4'h0;
	wire logic pready, pslverr, irq, rst_n, sel_n, lp, scl, sda, oe_n, lowp, resp;
	wire logic [31:0] prdata;
	// The interrupt line is open drain with a pull-up on the host side.
	wire logic drv, int_pin_n;
	assign int_pin_n = oe_n ? 1'b1 : drv;
	int mismatches = 0, check_count = 0;

	mms_status #(.LANES(4), .INIT_US(5)) mms_status_inst (
		.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_IRQ(irq), .I_MODULE_RESET_N(rst_n), .I_MODULE_SELECT_N(sel_n),
		.I_LOW_POWER_PIN(lp), .I_SCL(scl), .I_SDA(sda), .I_RX_LOS(los),
		.I_TX_FAULT(flt), .O_INTERRUPT_OUT_N_O(drv),
		.O_INTERRUPT_OUT_N_OE_N(oe_n), .O_LOW_POWER(lowp),
		.O_BUS_RESPOND(resp));
	mms_host_model host_inst (.i_clk(clk), .o_reset_n(rst_n),
		.o_select_n(sel_n), .o_lp(lp), .o_scl(scl), .o_sda(sda));

	initial forever #5 clk = ~clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20)
		begin
			mismatches++;
			report_and_stop();
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rd)
	endtask
	task automatic wait_pin(input logic lvl);
		int n;
		n = 0;
		while (int_pin_n !== lvl && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		`CHK("interrupt pin", lvl, int_pin_n)
		if (n >= 2000)
			report_and_stop();
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(`MMS_OFS_STATUS, 32'h1);
		wait_pin(1'b0);
		rdc(`MMS_OFS_STATUS, 32'hA);
		`CHK("respond", 1'b1, resp)
		rdc(`MMS_OFS_FLAGS, 32'h100);
		wait_pin(1'b1);
		apb(1'b1, `MMS_OFS_IRQ_MASK, 32'h1);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, `MMS_OFS_IRQ_STATUS, 32'hF);
		`CHK("irq", 1'b0, irq)
		host_inst.frame();
		@(posedge clk);
		repeat (4) @(posedge clk);
		rdc(`MMS_OFS_IRQ_STATUS, 32'h4);
		apb(1'b1, `MMS_OFS_IRQ_STATUS, 32'h4);
		for (int i = 0; i < 2; i++)
		begin
			los[0] <= (i == 0);
			flt[1] <= (i == 1);
			wait_pin(1'b0);
			los <= 4'h0;
			flt <= 4'h0;
			repeat (5) @(posedge clk);
			rdc(`MMS_OFS_FLAGS, i ? 32'h20 : 32'h1);
			wait_pin(1'b1);
		end
		apb(1'b1, `MMS_OFS_FLAG_MASK, 32'h8);
		los[3] <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("masked pin", 1'b1, int_pin_n)
		apb(1'b1, `MMS_OFS_FLAG_MASK, 32'h0);
		wait_pin(1'b0);
		los <= 4'h0;
		repeat (5) @(posedge clk);
		rdc(`MMS_OFS_FLAGS, 32'h8);
		host_inst.o_lp <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("low power", 1'b1, lowp)
		rdc(`MMS_OFS_STATUS, 32'hE);
		host_inst.o_lp <= 1'b0;
		repeat (6) @(posedge clk);
		apb(1'b1, `MMS_OFS_CONTROL, 32'h1);
		// The power output register follows the control bit one edge later.
		@(posedge clk);
		`CHK("low power", 1'b1, lowp)
		rdc(`MMS_OFS_CONTROL, 32'h1);
		apb(1'b1, `MMS_OFS_CONTROL, 32'h0);
		@(posedge clk);
		`CHK("low power", 1'b0, lowp)
		host_inst.o_select_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("respond", 1'b0, resp)
		host_inst.o_select_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("respond", 1'b1, resp)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("slave error", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		host_inst.hold_reset(50);
		repeat (6) @(posedge clk);
		`CHK("respond", 1'b1, resp)
		host_inst.hold_reset(250);
		`CHK("respond", 1'b0, resp)
		wait_pin(1'b0);
		rdc(`MMS_OFS_FLAGS, 32'h100);
		rdc(`MMS_OFS_IRQ_STATUS, 32'hB);
		report_and_stop();
	end
endmodule
`default_nettype wire
